// ==== core/pwm_cfg_pkg.sv ====
// package: register map, field positions and types of the pwm configuration/lock block
package pwm_cfg_pkg;

    localparam int ADDR_W = 8;

    // byte register offsets
    localparam logic [7:0] OFS_TIMEBASE_ALIGN = 8'h00;
    localparam logic [7:0] OFS_POLARITY_ACCEL = 8'h01;
    localparam logic [7:0] OFS_WAIT_FREEZE_SWAP = 8'h03;
    localparam logic [7:0] OFS_GEN_A_LO = 8'h20;
    localparam logic [7:0] OFS_GEN_A_HI = 8'h27;
    localparam logic [7:0] OFS_GEN_BC_LO = 8'h28;
    localparam logic [7:0] OFS_GEN_BC_HI = 8'h37;

    // timebase_alignment_config fields
    localparam int BIT_LOCK = 7;
    localparam int BIT_MULTI_TB = 6;
    localparam int BIT_ALIGN_C = 5;
    localparam int BIT_ALIGN_B = 4;
    localparam int BIT_ALIGN_A = 3;
    localparam int BIT_INDEP_C = 2;
    localparam int BIT_INDEP_B = 1;
    localparam int BIT_INDEP_A = 0;

    // polarity_accel_config fields
    localparam int BIT_ACCEL_EN = 7;
    localparam logic [7:0] POLARITY_ACCEL_WMASK = 8'hBF;

    // wait_freeze_swap_config fields
    localparam int BIT_WAIT_OFF = 7;
    localparam int BIT_FREEZE_OFF = 6;
    localparam int VLM_LSB = 3;
    localparam logic [7:0] WFS_FREE_WMASK = 8'hC0;
    localparam logic [7:0] WFS_ACCEL_WMASK = 8'h1F;

    // reset values
    localparam logic [7:0] RST_TIMEBASE_ALIGN = 8'h00;
    localparam logic [7:0] RST_POLARITY_ACCEL = 8'h00;
    localparam logic [7:0] RST_WAIT_FREEZE_SWAP = 8'h00;
    localparam logic [7:0] RST_GEN_REG = 8'h00;

    typedef enum logic [1:0] {
        VLM_INDEPENDENT = 2'b00,
        VLM_ZERO_TO_FIVE = 2'b01,
        VLM_ZERO_TO_THREE = 2'b10,
        VLM_RESERVED = 2'b11
    } value_load_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic multi_timebase_select;
        logic [2:0] edge_aligned;    // per pair c,b,a: 1 edge, 0 center
        logic [2:0] independent;     // per pair c,b,a: 1 independent, 0 complementary
        logic [2:0] swap;            // per pair c,b,a
        value_load_mode_t value_load_mode;
        logic [5:0] invert;          // per channel
    } pair_cfg_t;

endpackage

// ==== core/pwm_pair_config_lock.sv ====
// pwm pair configuration, polarity and write-protect lock block
//
// Operation
// - lock bit blocks writes to protectable registers
// - lock bit cannot be cleared by write
// - multi timebase bit sticky until reset
// - multi timebase opens generator b/c range
// - single timebase: b/c range reads zero
// - alignment bit: 0 center, 1 edge
// - single timebase: pair a alignment everywhere
// - operation bit: 0 complementary, 1 independent
// - alignment and operation bits lock-protected
// - polarity/accel register readable, frozen when locked
// - positive polarity: high when count<=width
// - negative polarity: low when count<=width
// - six polarity bits map channels 0..5
// - accel bit gates load-mode and swap writes
// - load mode codes: 00/11 independent, 01, 10
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/10ps
module pwm_pair_config_lock
    import pwm_cfg_pkg::*;
#(
    parameter int CNT_W = 15
) (
    input wire logic mclk,                     // peripheral clock
    input wire logic reset,                    // synchronous reset, active high
    input wire logic [ADDR_W-1:0] addr,        // register byte offset
    input wire logic [7:0] wdata,              // write data
    input wire logic wr,                       // write strobe
    input wire logic rd,                       // read strobe
    input wire logic [5:0][CNT_W-1:0] count,   // counter value seen by each channel
    input wire logic [5:0][CNT_W-1:0] width,   // pulse-width value of each channel
    output logic [7:0] rdata,                  // read data, valid the cycle after rd
    output logic lock,                         // write-protect lock state
    output pair_cfg_t cfg,                     // effective configuration for the generators
    output logic [5:0] pwm_channel_outputs     // polarity-applied channel outputs
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg_req_t req;
    logic [7:0] timebase_alignment_config;
    logic [7:0] polarity_accel_config;
    logic [7:0] wait_freeze_swap_config;
    logic [7:0] gen_regs [OFS_GEN_A_LO:OFS_GEN_BC_HI];

    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    function automatic logic in_gen_bc(input logic [ADDR_W-1:0] a);
        return (a >= OFS_GEN_BC_LO) && (a <= OFS_GEN_BC_HI);
    endfunction

    function automatic logic in_gen_any(input logic [ADDR_W-1:0] a);
        return (a >= OFS_GEN_A_LO) && (a <= OFS_GEN_BC_HI);
    endfunction

    wire logic locked = timebase_alignment_config[BIT_LOCK];
    wire logic multi_tb = timebase_alignment_config[BIT_MULTI_TB];
    wire logic accel_en = polarity_accel_config[BIT_ACCEL_EN];

    // ------------------------------------------------------------
    // timebase / alignment register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            timebase_alignment_config <= RST_TIMEBASE_ALIGN;
        end else if (req.wr && req.addr == OFS_TIMEBASE_ALIGN) begin
            // lock and multi-timebase only ever set; reset is the sole clear
            if (req.wdata[BIT_LOCK]) begin
                timebase_alignment_config[BIT_LOCK] <= 1'b1;
            end
            if (req.wdata[BIT_MULTI_TB]) begin
                timebase_alignment_config[BIT_MULTI_TB] <= 1'b1;
            end
            // alignment and operation bits freeze once locked, silently
            if (!locked) begin
                timebase_alignment_config[5:0] <= req.wdata[5:0];
            end
        end
    end

    // ------------------------------------------------------------
    // polarity / acceleration register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            polarity_accel_config <= RST_POLARITY_ACCEL;
        end else if (req.wr && req.addr == OFS_POLARITY_ACCEL && !locked) begin
            polarity_accel_config <= req.wdata & POLARITY_ACCEL_WMASK;
        end
    end

    // ------------------------------------------------------------
    // wait/freeze/swap register: accel-gated fields
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            wait_freeze_swap_config <= RST_WAIT_FREEZE_SWAP;
        end else if (req.wr && req.addr == OFS_WAIT_FREEZE_SWAP) begin
            wait_freeze_swap_config[7:6] <= req.wdata[7:6];
            if (accel_en) begin
                wait_freeze_swap_config[4:0] <= req.wdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // generator register range, upper 16 b/c bytes only with multi timebase
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            for (int i = OFS_GEN_A_LO; i <= OFS_GEN_BC_HI; i++) begin
                gen_regs[i] <= RST_GEN_REG;
            end
        end else if (req.wr && in_gen_any(req.addr) && (multi_tb || !in_gen_bc(req.addr))) begin
            gen_regs[req.addr] <= req.wdata;
        end
    end

    // ------------------------------------------------------------
    // read path, one cycle latency, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            if (req.addr == OFS_TIMEBASE_ALIGN) begin
                rdata <= timebase_alignment_config;
            end else if (req.addr == OFS_POLARITY_ACCEL) begin
                rdata <= polarity_accel_config;
            end else if (req.addr == OFS_WAIT_FREEZE_SWAP) begin
                rdata <= wait_freeze_swap_config;
            end else if (in_gen_bc(req.addr)) begin
                rdata <= multi_tb ? gen_regs[req.addr] : 8'h00;
            end else if (in_gen_any(req.addr)) begin
                rdata <= gen_regs[req.addr];
            end else begin
                rdata <= 8'h00;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // effective configuration
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg <= '0;
            lock <= 1'b0;
        end else begin
            lock <= locked;
            cfg.multi_timebase_select <= multi_tb;
            cfg.edge_aligned[0] <= timebase_alignment_config[BIT_ALIGN_A];
            // pairs b and c follow pair a under a single timebase
            cfg.edge_aligned[1] <= multi_tb ? timebase_alignment_config[BIT_ALIGN_B]
                                            : timebase_alignment_config[BIT_ALIGN_A];
            cfg.edge_aligned[2] <= multi_tb ? timebase_alignment_config[BIT_ALIGN_C]
                                            : timebase_alignment_config[BIT_ALIGN_A];
            cfg.independent <= timebase_alignment_config[BIT_INDEP_C:BIT_INDEP_A];
            cfg.swap <= wait_freeze_swap_config[2:0];
            // reserved load-mode code behaves as independent access
            if (value_load_mode_t'(wait_freeze_swap_config[VLM_LSB+:2]) == VLM_RESERVED) begin
                cfg.value_load_mode <= VLM_INDEPENDENT;
            end else begin
                cfg.value_load_mode <= value_load_mode_t'(wait_freeze_swap_config[VLM_LSB+:2]);
            end
            cfg.invert <= polarity_accel_config[5:0];
        end
    end

    // ------------------------------------------------------------
    // channel polarity
    // ------------------------------------------------------------
    generate
        for (genvar ch = 0; ch < 6; ch++) begin : g_chan
            always_ff @(posedge mclk) begin
                if (reset) begin
                    pwm_channel_outputs[ch] <= 1'b0;
                end else begin
                    // inverted channel is low during the active part
                    pwm_channel_outputs[ch] <= (count[ch] <= width[ch]) ^ polarity_accel_config[ch];
                end
            end
        end
    endgenerate

endmodule

// ==== bench/pwm_cfg_monitor.sv ====
// checker for the pwm configuration and lock block
`timescale 1ns/10ps
module pwm_cfg_monitor import pwm_cfg_pkg::*; (
    input wire logic mclk, // clock
    input wire logic reset, // sync reset
    input wire logic [ADDR_W-1:0] addr, // offset
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [7:0] rdata, // read data
    input wire logic lock, // lock state
    input wire pair_cfg_t cfg // configuration
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    property p_lock_set; wr && addr == OFS_TIMEBASE_ALIGN && wdata[BIT_LOCK] |-> ##2 lock; endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_lock_hold; lock |=> lock; endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock cleared");
    property p_mtb_hold; cfg.multi_timebase_select |=> cfg.multi_timebase_select; endproperty
    a_mtb_hold: assert property (p_mtb_hold) else $error("timebase select cleared");
    property p_frozen; lock |=> $stable({cfg.independent, cfg.invert, cfg.edge_aligned[0]}); endproperty
    a_frozen: assert property (p_frozen) else $error("locked field moved");
    property p_single_tb; !cfg.multi_timebase_select |-> cfg.edge_aligned == {3{cfg.edge_aligned[0]}}; endproperty
    a_single_tb: assert property (p_single_tb) else $error("alignment not shared");
    property p_bc_zero; rd && addr >= OFS_GEN_BC_LO && addr <= OFS_GEN_BC_HI && !cfg.multi_timebase_select
        |=> rdata == 8'h00; endproperty
    a_bc_zero: assert property (p_bc_zero) else $error("closed range read nonzero");
    property p_vlm; cfg.value_load_mode != VLM_RESERVED; endproperty
    a_vlm: assert property (p_vlm) else $error("reserved load mode passed on");
    property p_lock_read; rd && addr == OFS_TIMEBASE_ALIGN && lock |=> rdata[BIT_LOCK]; endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock not read back");
endmodule
bind pwm_pair_config_lock pwm_cfg_monitor mon (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .lock(lock), .cfg(cfg));

// ==== bench/gate_driver_model.sv ====
// partner model: gate drivers following the pwm pins one cycle late
`timescale 1ns/10ps
module gate_driver_model (
    input wire logic mclk, // clock
    input wire logic [5:0] pwm_in, // pwm pins
    output logic [5:0] gate // driven gate levels
);
    always_ff @(posedge mclk) gate <= pwm_in;
endmodule

// ==== bench/tb_pwm_pair_config_lock.sv ====
// testbench for the pwm configuration and lock block
`timescale 1ns/10ps
module tb_pwm_pair_config_lock import pwm_cfg_pkg::*; ;
    logic mclk = 0, reset = 1, wr = 0, rd = 0, lock;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic [5:0][14:0] count = '0, width = '0;
    logic [14:0] c;
    logic [5:0] pwm, gate;
    pair_cfg_t cfg;
    int n_mismatch = 0, num_checks = 0;
    logic [16:0] ops [28] = '{17'h1_0100, 17'h1_031F, 17'h0_0300, 17'h1_0180, 17'h1_030D, 17'h0_030D,
        17'h1_0315, 17'h0_0315, 17'h1_031D, 17'h0_031D, 17'h1_28A5, 17'h0_2800, 17'h1_205A, 17'h0_205A,
        17'h0_4000, 17'h1_0070, 17'h1_37C3, 17'h0_37C3, 17'h1_0000, 17'h0_0040, 17'h1_018C, 17'h1_00D5,
        17'h1_002A, 17'h0_00D5, 17'h1_0100, 17'h0_018C, 17'h1_03C2, 17'h0_03C2};
    always #5 mclk = ~mclk;
    pwm_pair_config_lock #(.CNT_W(15)) uut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .count(count), .width(width), .rdata(rdata), .lock(lock), .cfg(cfg), .pwm_channel_outputs(pwm));
    gate_driver_model drv (.mclk(mclk), .pwm_in(pwm), .gate(gate));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // op: write flag, offset, data; a read carries the value expected back
    task automatic acc(input logic [16:0] op);
        addr <= op[15:8];
        wdata <= op[7:0];
        wr <= op[16];
        rd <= !op[16];
        @(posedge mclk);
        wr <= 0;
        rd <= 0;
        #1 if (!op[16]) chk(rdata, op[7:0]);
        @(posedge mclk);
    endtask
    function automatic logic [5:0] pol(input logic [5:0][14:0] n, input logic [5:0][14:0] w, input logic [5:0] v);
        for (int i = 0; i < 6; i++) pol[i] = (n[i] <= w[i]) ^ v[i];
    endfunction
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial #100000 begin
        n_mismatch++;
        give_verdict();
    end
    initial begin
        void'($urandom(77));
        repeat (2) @(posedge mclk);
        reset <= 0;
        repeat (8) begin
            d = 8'($urandom) & 8'h3F;
            acc({1'b1, OFS_TIMEBASE_ALIGN, d});
            #1 chk(8'({cfg.edge_aligned, cfg.independent}), 8'({{3{d[3]}}, d[2:0]}));
            @(posedge mclk);
            d = 8'($urandom) & 8'hBF;
            acc({1'b1, OFS_POLARITY_ACCEL, d});
            for (int i = 0; i < 6; i++) begin
                c = 15'($urandom);
                count[i] <= c;
                width[i] <= (i == 0) ? c : 15'($urandom); // channel 0 sits on the equal boundary
            end
            repeat (2) @(posedge mclk);
            #1 chk(8'(pwm), 8'(pol(count, width, d[5:0])));
            chk(8'(gate), 8'(pol(count, width, d[5:0])));
            @(posedge mclk);
        end
        $display("polarity test done");
        for (int k = 0; k < 28; k++) acc(ops[k]);
        // last load-mode write was 00 with swap 010, accel still open when it landed
        #1 chk(8'({cfg.value_load_mode, cfg.swap}), 8'h02);
        chk(8'(lock), 8'h01);
        @(posedge mclk);
        $display("register test done");
        reset <= 1;
        repeat (2) @(posedge mclk);
        reset <= 0;
        acc(17'h0_0000);
        $display("reset test done");
        give_verdict();
    end
endmodule
